// ==== ccf_cfg.svh ====
/*
  Constants of the logic cluster control fabric: sizes, bit positions of the
  local-routing control lines and reset values.
  Assumes nothing else; included by bare name wherever the numbers are needed.
*/
`ifndef CCF_CFG_SVH
`define CCF_CFG_SVH

// ==========================================================================
// cluster sizes
`define CCF_CELLS        10
`define CCF_EXT_INPUTS   26
`define CCF_COL_CLOCKS   4
`define CCF_MAX_CTRL     10
`define CCF_CTRL_W       4

// ==========================================================================
// external input map: operand a, operand b, then control lines
`define CCF_A_LSB        0
`define CCF_B_LSB        10
`define CCF_GATE_ONE     20
`define CCF_GATE_TWO     21
`define CCF_SCLR         22
`define CCF_SLOAD        23
`define CCF_ALOAD        24
`define CCF_ADDNSUB      25

// ==========================================================================
// operand b sources on the local routing
`define CCF_BSRC_EXT     2'h0
`define CCF_BSRC_FB      2'h1
`define CCF_BSRC_LEFT    2'h2
`define CCF_BSRC_RIGHT   2'h3

// ==========================================================================
// reset values and fixed control count
`define CCF_Q_RST        10'h000
`define CCF_COL_RST      4'h0
`define CCF_CTRL_FIXED   4'h4

`endif

// ==== ccf_pkg.sv ====
/*
  Types of the logic cluster control fabric: the static configuration word
  and the data-path mode of the cluster's cells.
  Assumes ccf_cfg.svh is on the include path.
*/
`include "ccf_cfg.svh"

package ccf_pkg;

  // ========================================================================
  // what each cell's register takes on an enabled edge
  typedef enum logic [2:0] {
    CCF_D_LUT   = 3'h1,
    CCF_D_SUM   = 3'h2,
    CCF_D_CHAIN = 3'h4
  } ccf_dsel_t;

  // ========================================================================
  // static configuration, held steady by the surrounding logic
  typedef struct packed {
    logic [1:0]                clk_one_src;   // column line for clock one
    logic [1:0]                clk_two_src;   // column line for clock two
    logic                      dual_edge;     // clock two = falling edge of one
    logic                      aclr_one_en;
    logic                      aclr_two_en;
    logic [1:0]                aclr_one_src;  // global line for clear one
    logic [1:0]                aclr_two_src;  // global line for clear two
    logic [`CCF_CELLS-1:0]     cell_clk_two;  // cell runs on clock two
    logic [`CCF_CELLS-1:0]     cell_aclr_two; // cell obeys clear two
    logic [`CCF_CELLS-1:0]     pushback;      // preset by inverted clear
    logic [`CCF_CELLS-1:0]     preset_mode;   // async load forces one
    logic [1:0]                b_src;         // operand b routing source
    ccf_dsel_t                 dsel;
    logic [7:0]                lut_mask;      // truth table of {a, b, chain}
  } ccf_cfg_t;

endpackage : ccf_pkg

// ==== ccf_cluster.sv ====
/*
  One logic cluster: ten cell registers with their cluster-wide control
  generation, carry chain, lookup and register chains and local routing.
  Assumes all inputs are synchronous to i_clock; the column clock lines are
  levels sampled on i_clock, their edges becoming one-cycle enables.
*/
`timescale 1ns/1ps
`include "ccf_cfg.svh"

// What this block does
// - ten cells with chains, controls and routing
// - twenty-six external inputs plus ten feedback lines
// - ten control kinds, at most ten active
// - each cluster clock paired with its gate
// - both edges of one clock use both clocks
// - dropped gate stops clock, registers hold
// - preset by inverted clear or async load high
// - cluster add/subtract select, dynamic per data
// - controls from four column clocks and routing
// - global lines serve as clocks or clears
// - routing from rows, own cells, both neighbours
// - each cell output reaches thirty cells
// - register and lookup chains to adjacent cell
// - subtract inverts b, first carry-in one
// - sync clear and load hit every register
module ccf_cluster (
  input  wire logic                         i_clock,        // system clock, 50 MHz
  input  wire logic                         i_sys_rst,      // async reset, high
  input  wire ccf_pkg::ccf_cfg_t            i_cfg,          // static configuration
  input  wire logic [`CCF_COL_CLOCKS-1:0]   i_col_clk,      // global column lines
  input  wire logic [`CCF_EXT_INPUTS-1:0]   i_ext_in,       // row/column routing
  input  wire logic [`CCF_CELLS-1:0]        i_left_link,    // left neighbour cells
  input  wire logic [`CCF_CELLS-1:0]        i_right_link,   // right neighbour cells
  input  wire logic                         i_carry_in,     // carry from prior cluster
  input  wire logic                         i_lut_chain_in, // lookup chain into cell 0
  input  wire logic                         i_reg_chain_in, // register chain into cell 0
  output logic      [`CCF_CELLS-1:0]        o_cell_q,       // cell register outputs
  output logic      [`CCF_CELLS-1:0]        o_lut_q,        // registered lookup outputs
  output logic                              o_carry_out,    // registered chain carry
  output logic      [`CCF_CTRL_W-1:0]       o_ctrl_used     // active control count
);
  import ccf_pkg::*;

  localparam int unsigned N = `CCF_CELLS;

  // ========================================================================
  // helpers
  function automatic logic pick_line(input logic [`CCF_COL_CLOCKS-1:0] lines,
                                     input logic [1:0] sel);
    pick_line = lines[sel];
  endfunction

  logic [N-1:0]                q_reg;
  logic [N-1:0]                q_next;
  logic [`CCF_COL_CLOCKS-1:0]  col_prev_reg;
  logic [N-1:0]                op_a;
  logic [N-1:0]                op_b_raw;
  logic [N-1:0]                op_b;
  logic [N-1:0]                lut_v;
  logic [N-1:0]                sum_v;
  logic [N:0]                  carry_v;
  logic [N-1:0]                d_v;
  logic                        tick_one;
  logic                        tick_two;
  logic                        clr_one;
  logic                        clr_two;
  logic                        gate_one;
  logic                        gate_two;
  logic                        sclr;
  logic                        sload;
  logic                        aload;
  logic                        sub;
  logic [`CCF_CTRL_W-1:0]      used_next;

  // ========================================================================
  // local routing: control lines and operands from the external inputs
  assign op_a     = i_ext_in[`CCF_A_LSB +: N];
  assign gate_one = i_ext_in[`CCF_GATE_ONE];
  assign gate_two = i_ext_in[`CCF_GATE_TWO];
  assign sclr     = i_ext_in[`CCF_SCLR];
  assign sload    = i_ext_in[`CCF_SLOAD];
  assign aload    = i_ext_in[`CCF_ALOAD];
  assign sub      = i_ext_in[`CCF_ADDNSUB];

  // operand b may come from rows, own feedback or either neighbour
  always_comb begin
    unique case (i_cfg.b_src)
      `CCF_BSRC_EXT:   op_b_raw = i_ext_in[`CCF_B_LSB +: N];
      `CCF_BSRC_FB:    op_b_raw = q_reg;
      `CCF_BSRC_LEFT:  op_b_raw = i_left_link;
      `CCF_BSRC_RIGHT: op_b_raw = i_right_link;
    endcase
  end

  // ========================================================================
  // column line edge history; lines are levels, edges become enables
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      col_prev_reg <= `CCF_COL_RST;
    end else begin
      col_prev_reg <= i_col_clk;
    end
  end

  // cluster clocks from column lines, each gated by its own enable
  always_comb begin
    tick_one = pick_line(i_col_clk, i_cfg.clk_one_src)
             & ~pick_line(col_prev_reg, i_cfg.clk_one_src)
             & gate_one;
    if (i_cfg.dual_edge) begin
      // falling edge of the same line consumes the second clock
      tick_two = ~pick_line(i_col_clk, i_cfg.clk_one_src)
               & pick_line(col_prev_reg, i_cfg.clk_one_src)
               & gate_two;
    end else begin
      tick_two = pick_line(i_col_clk, i_cfg.clk_two_src)
               & ~pick_line(col_prev_reg, i_cfg.clk_two_src)
               & gate_two;
    end
    // global lines doubling as asynchronous clears
    clr_one = i_cfg.aclr_one_en & pick_line(i_col_clk, i_cfg.aclr_one_src);
    clr_two = i_cfg.aclr_two_en & pick_line(i_col_clk, i_cfg.aclr_two_src);
  end

  // ========================================================================
  // arithmetic and lookup data paths of the ten cells
  assign op_b = op_b_raw ^ {N{sub}};

  always_comb begin
    carry_v[0] = sub | i_carry_in;
    for (int i = 0; i < N; i++) begin
      sum_v[i]     = op_a[i] ^ op_b[i] ^ carry_v[i];
      carry_v[i+1] = (op_a[i] & op_b[i]) | (carry_v[i] & (op_a[i] ^ op_b[i]));
      lut_v[i]     = i_cfg.lut_mask[{op_a[i], op_b[i],
                       (i == 0) ? i_lut_chain_in : lut_v[i-1]}];
      unique case (i_cfg.dsel)
        CCF_D_LUT:   d_v[i] = lut_v[i];
        CCF_D_SUM:   d_v[i] = sum_v[i];
        CCF_D_CHAIN: d_v[i] = (i == 0) ? i_reg_chain_in : q_reg[i-1];
        default:     d_v[i] = q_reg[i];                 // illegal code holds
      endcase
    end
  end

  // ========================================================================
  // per-cell register next value; async controls beat clocked ones
  always_comb begin
    for (int i = 0; i < N; i++) begin
      q_next[i] = q_reg[i];
      if (i_cfg.cell_aclr_two[i] ? clr_two : clr_one) begin
        q_next[i] = 1'b0;
      end else if (aload) begin
        if (i_cfg.preset_mode[i]) begin
          // push-back clears the inverted store; otherwise load a tied one
          q_next[i] = i_cfg.pushback[i] ? ~1'b0 : 1'b1;
        end else begin
          q_next[i] = op_a[i];
        end
      end else if (i_cfg.cell_clk_two[i] ? tick_two : tick_one) begin
        if (sclr) begin
          q_next[i] = 1'b0;
        end else if (sload) begin
          q_next[i] = op_a[i];
        end else begin
          q_next[i] = d_v[i];
        end
      end
    end
  end

  // ========================================================================
  // cell registers; outputs feed own cluster and both neighbours
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      q_reg <= `CCF_Q_RST;
    end else begin
      q_reg <= q_next;
    end
  end

  assign o_cell_q = q_reg;

  // registered lookup and carry views for the next cluster
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_lut_q     <= `CCF_Q_RST;
      o_carry_out <= 1'b0;
    end else begin
      o_lut_q     <= lut_v;
      o_carry_out <= carry_v[N];
    end
  end

  // ========================================================================
  // control usage: each used clock brings its gate along
  always_comb begin
    used_next = `CCF_CTRL_FIXED;
    if (~&i_cfg.cell_clk_two) used_next = used_next + `CCF_CTRL_W'(2);
    if (|i_cfg.cell_clk_two)  used_next = used_next + `CCF_CTRL_W'(2);
    used_next = used_next + `CCF_CTRL_W'(i_cfg.aclr_one_en)
                          + `CCF_CTRL_W'(i_cfg.aclr_two_en);
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_ctrl_used <= '0;
    end else begin
      o_ctrl_used <= used_next;
    end
  end

  // ========================================================================
  // checks
  ctrl_limit_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    o_ctrl_used <= `CCF_MAX_CTRL) else $error("too many cluster controls");

  gate_one_hold_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (!gate_one && !aload && !clr_one && !clr_two && !i_cfg.cell_clk_two[0])
      |=> $stable(q_reg[0])) else $error("gated cell one changed");

  clock_pair_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (!gate_two && !i_cfg.dual_edge) |-> !tick_two) else $error("clock two ran ungated");

  dual_edge_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (i_cfg.dual_edge && i_cfg.cell_clk_two[4] && !aload && !clr_one && !clr_two
     && pick_line(i_col_clk, i_cfg.clk_one_src)) |=> $stable(q_reg[4]))
    else $error("clock two cell moved off falling edge");

  async_clear_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (clr_one && !i_cfg.cell_aclr_two[3]) |=> !q_reg[3]) else $error("clear one missed");

  preset_high_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (aload && !clr_one && !clr_two && i_cfg.preset_mode[5]) |=> q_reg[5])
    else $error("preset did not set cell");

  sync_clear_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (tick_one && sclr && !aload && !clr_one && !clr_two && ~|i_cfg.cell_clk_two)
      |=> q_reg == '0) else $error("sync clear missed a cell");

  subtract_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    sub |-> sum_v == N'(op_a - op_b_raw)) else $error("subtract result wrong");

  reg_chain_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (i_cfg.dsel == CCF_D_CHAIN && tick_one && !sclr && !sload && !aload
     && !clr_one && !clr_two && !i_cfg.cell_clk_two[1])
      |=> q_reg[1] == $past(q_reg[0])) else $error("register chain broken");

endmodule // ccf_cluster

// ==== ccf_rule_note_unused.sv ====
`timescale 1ns/1ps

// ==== ccf_nbr_model.sv ====
/*
  Far side of one logic cluster: global column lines and both neighbours.
  Assumes the bench calls its tasks from falling-edge context only.
*/
`timescale 1ns/1ps
`include "ccf_cfg.svh"

// ==========================================================================
// column lines and neighbour cells
module ccf_nbr_model (
  input  wire logic                       i_clock,   // system clock
  output logic      [`CCF_COL_CLOCKS-1:0] o_col_clk, // global column lines
  output logic      [`CCF_CELLS-1:0]      o_left,    // left cluster cells
  output logic      [`CCF_CELLS-1:0]      o_right    // right cluster cells
);
  // lines idle low: a column line only moves when a pulse or a hold is asked for
  initial begin
    o_col_clk = `CCF_COL_RST;
    o_left    = 10'h155;
    o_right   = 10'h0aa;
  end
  // one high sample on a column line, changed just after falling edges
  task automatic pulse(input int line);
    @(negedge i_clock);
    o_col_clk[line] = 1'b1;
    @(negedge i_clock);
    o_col_clk[line] = 1'b0;
  endtask
  // a global line used as a level, such as a clear
  task automatic hold(input int line, input logic lvl);
    o_col_clk[line] = lvl;
  endtask
endmodule // ccf_nbr_model

// ==== tb.sv ====
/*
  Self-checking bench of the logic cluster: scenarios drive routing, column lines
  and configuration, then judge cell outputs and, in some, lookup, carry and count.
  Assumes ccf_pkg, ccf_cfg.svh and ccf_nbr_model are compiled first.
*/
`timescale 1ns/1ps
`include "ccf_cfg.svh"

`define CHK(nm, e, g) begin \
  check_count++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); \
  end \
end

module tb;
  import ccf_pkg::*;
  // ========================================================================
  // clock, stimulus and observed wires
  logic                       i_clock   = 1'b0;
  logic                       i_sys_rst = 1'b1;
  ccf_cfg_t                   cfg;
  logic [`CCF_EXT_INPUTS-1:0] ext       = '0;
  logic                       cin       = 1'b0;
  logic                       lchain    = 1'b0;
  logic                       rchain    = 1'b0;
  logic [`CCF_COL_CLOCKS-1:0] col;
  logic [`CCF_CELLS-1:0]      left, right, q, lut, old;
  logic                       cout;
  logic [`CCF_CTRL_W-1:0]     used;
  int                         fail_count  = 0;
  int                         check_count = 0;

  always #10 i_clock = ~i_clock;

  ccf_nbr_model nbr (.i_clock(i_clock), .o_col_clk(col), .o_left(left), .o_right(right));

  ccf_cluster DUT (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_cfg(cfg), .i_col_clk(col),
    .i_ext_in(ext), .i_left_link(left), .i_right_link(right), .i_carry_in(cin),
    .i_lut_chain_in(lchain), .i_reg_chain_in(rchain), .o_cell_q(q), .o_lut_q(lut),
    .o_carry_out(cout), .o_ctrl_used(used)
  );

  // ========================================================================
  // helpers: plain config, expected sum, one column-one pulse
  function automatic ccf_cfg_t base();
    ccf_cfg_t c;
    c              = '0;
    c.clk_one_src  = 2'h1;
    c.clk_two_src  = 2'h2;
    c.aclr_one_src = 2'h3;
    c.aclr_two_src = 2'h3;
    c.b_src        = `CCF_BSRC_EXT;
    c.dsel         = CCF_D_SUM;
    c.lut_mask     = 8'hc0;
    return c;
  endfunction
  function automatic logic [10:0] addx(input logic [9:0] a, b, input logic s, ci);
    return {1'b0, a} + {1'b0, b ^ {10{s}}} + 11'(s | ci);
  endfunction
  // extra cycle so a falling column edge is also sampled
  task automatic fire();
    nbr.pulse(1);
    @(negedge i_clock);
  endtask
  task automatic sum_once(input logic [9:0] a, b, input logic s, ci);
    logic [10:0] e;
    e   = addx(a, b, s, ci);
    cin = ci;
    ext = {s, 5'h01, b, a};
    fire();
    `CHK("sum", e[9:0], q)
    `CHK("carry", e[10], cout)
    `CHK("lookup", a & (b ^ {10{s}}), lut)
  endtask

  // ========================================================================
  // scenarios
  task automatic t_sum();
    cfg = base();
    sum_once(10'h003, 10'h001, 1'b0, 1'b1);
    sum_once(10'h003, 10'h001, 1'b1, 1'b1);
    sum_once(10'h3ff, 10'h001, 1'b0, 1'b0);
    sum_once(10'h000, 10'h001, 1'b1, 1'b0);
    `CHK("count", 4'h6, used)
  endtask
  // gate two must not clock cells that run on clock one
  task automatic t_gate();
    old = q;
    ext = {1'b0, 5'h02, 10'h001, 10'h005};
    fire();
    `CHK("gate two only", old, q)
    ext = {1'b0, 5'h00, 10'h001, 10'h005};
    fire();
    `CHK("gates low", old, q)
  endtask
  task automatic t_dual();
    logic [10:0] e;
    cfg              = base();
    cfg.dual_edge    = 1'b1;
    cfg.cell_clk_two = 10'h0f0;
    cfg.aclr_one_en  = 1'b1;
    cfg.aclr_two_en  = 1'b1;
    old              = q;
    e                = addx(10'h005, 10'h002, 1'b0, 1'b0);
    ext              = {1'b0, 5'h02, 10'h002, 10'h005};
    fire();
    `CHK("falling edge cells", (old & ~10'h0f0) | (e[9:0] & 10'h0f0), q)
    `CHK("count", 4'ha, used)
  endtask
  // sync controls wait for an enabled tick
  task automatic t_sync();
    cfg = base();
    ext = {1'b0, 5'h09, 10'h000, 10'h2a5};
    fire();
    `CHK("sync load", 10'h2a5, q)
    ext = {1'b0, 5'h05, 10'h000, 10'h2a5};
    repeat (3) @(negedge i_clock);
    `CHK("sync clear no tick", 10'h2a5, q)
    fire();
    `CHK("sync clear", 10'h000, q)
  endtask
  // preset cells ignore load data; cells 0 and 1 obey clear two only
  task automatic t_async();
    cfg.preset_mode   = 10'h02f;
    cfg.pushback      = 10'h005;
    ext               = {1'b0, 5'h10, 10'h000, 10'h080};
    repeat (2) @(negedge i_clock);
    `CHK("async load", 10'h0af, q)
    ext               = '0;
    cfg.aclr_one_en   = 1'b1;
    cfg.aclr_two_en   = 1'b1;
    cfg.aclr_two_src  = 2'h0;
    cfg.cell_aclr_two = 10'h003;
    nbr.hold(3, 1'b1);
    repeat (2) @(negedge i_clock);
    `CHK("async clear one", 10'h003, q)
    `CHK("count", 4'h8, used)
    nbr.hold(0, 1'b1);
    @(negedge i_clock);
    `CHK("async clear two", 10'h000, q)
    nbr.hold(3, 1'b0);
    @(negedge i_clock);
    nbr.hold(0, 1'b0);
    @(negedge i_clock);
  endtask
  task automatic t_chain();
    cfg          = base();
    cfg.dsel     = CCF_D_CHAIN;
    cfg.lut_mask = 8'haa;
    rchain       = 1'b1;
    lchain       = 1'b1;
    ext          = {1'b0, 5'h01, 20'h00000};
    fire();
    `CHK("reg chain", 10'h001, q)
    `CHK("lookup chain", 10'h3ff, lut)
    rchain = 1'b0;
    fire();
    `CHK("reg chain shift", 10'h002, q)
    cfg.dsel = CCF_D_LUT;
    fire();
    `CHK("lookup register", 10'h3ff, q)
  endtask
  // left, own feedback, right: each feeds operand b
  task automatic t_route();
    logic [9:0] src;
    cfg = base();
    ext = {1'b0, 5'h01, 10'h000, 10'h001};
    foreach (src[k]) begin
      if (k < 3) begin
        cfg.b_src = (k == 0) ? `CCF_BSRC_LEFT : (k == 1) ? `CCF_BSRC_FB : `CCF_BSRC_RIGHT;
        src       = (k == 0) ? left : (k == 1) ? q : right;
        fire();
        `CHK("routed sum", src + 10'h001, q)
      end
    end
  endtask

  // ========================================================================
  // verdict and run control
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // the whole run is well under a hundred cycles
  initial begin
    #40000;
    fail_count++;
    tally_and_finish();
  end

  initial begin
    cfg = base();
    repeat (6) @(posedge i_clock);
    @(negedge i_clock);
    `CHK("reset cells", 10'h000, q)
    `CHK("reset lookup", 10'h000, lut)
    `CHK("reset carry", 1'b0, cout)
    `CHK("reset count", 4'h0, used)
    i_sys_rst = 1'b0;
    t_sum();
    t_gate();
    t_dual();
    t_sync();
    t_async();
    t_chain();
    t_route();
    tally_and_finish();
  end
endmodule // tb
